// file: hdl/annp_regs.sv
// Purpose: Next page transmit and receive register bank with page flag
// Assumes: Avalon-MM slave, byte addresses, one wait state per access
// Notes:   Arbitration logic outside supplies received pages and send pulses
//
// Contract
// R1: Transmit register holds the next page sent to the partner.
// R2: Bit 15 transmit is writable more-pages request, resets 0.
// R3: Bit 14 transmit is read-only local acknowledge, resets 0.
// R4: Bit 13 transmit writable message page flag, resets 1.
// R5: Bit 12 transmit writable comply flag, resets 0.
// R6: Bit 11 transmit read-only toggle, inverse of previous exchanged toggle.
// R7: Bits 10:0 writable code field, message or unformatted data.
// R8: Code field resets to one, the null message page.
// R9: Receive register captures partner page, same field layout.
// R10: Bit 15 receive shows partner wants more pages, resets 0.
// R11: Bit 14 receive shows partner acknowledge, read-only.
// R12: Bit 13 receive message page flag, resets 1.
// R13: Bit 12 receive shows partner comply flag.
// R14: Bit 11 receive toggle, read-only.
// R15: Page received flag sets on arrival, clears on software read.
// R16: Next pages land in the receive register, not base page register.
// R17: Receive register updates whole before page received flag rises.
// R18: Software writes next outgoing page after each page received.
`timescale 1ns/10ps
module annp_regs
  import annp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0]      readdata,
  output logic                   waitrequest,
  // Arbitration side
  input  wire logic              rx_page_valid,
  input  wire logic [PAGE_W-1:0] rx_page_word,
  input  wire logic              local_ack,
  input  wire logic              tx_page_sent,
  output logic [PAGE_W-1:0]      tx_page,
  output logic                   page_rx_flag
);

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  // True when the byte address selects the register of given index
  function automatic logic annp_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [3:0]        idx);
    annp_hit = (addr == {idx, 2'b00});
  endfunction : annp_hit

  logic              wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [PAGE_W-1:0] xmit_ff;
  logic              page_rx_ff;
  logic [PAGE_W-1:0] recv_page;
  logic              recv_done;

  wire               hit_expand = annp_hit(address, IDX_EXPAND);
  wire               hit_xmit   = annp_hit(address, IDX_XMIT);
  wire               hit_recv   = annp_hit(address, IDX_RECV);
  wire               hit_any    = hit_expand | hit_xmit | hit_recv;

  // Access completes at the edge where waitrequest is low
  wire               wr_fire    = write & ~wait_ff;
  wire               rd_fire    = read & ~wait_ff;
  wire               rd_load    = read & wait_ff;
  wire               xmit_wr    = wr_fire & hit_xmit;
  wire               cor_fire   = rd_fire & hit_expand;

  // -----------------------------------------------------------------
  // Byte lane merge for the transmit page
  // -----------------------------------------------------------------
  wire  [PAGE_W-1:0] lane_mask;
  genvar             g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lane
      assign lane_mask[g*8 +: 8] = {8{byteenable[g]}};
    end
  endgenerate

  wire  [PAGE_W-1:0] wr_mask    = lane_mask & XMIT_WR_MASK;
  wire  [PAGE_W-1:0] wr_page    = (xmit_ff & ~wr_mask)
                                | (writedata[PAGE_W-1:0] & wr_mask);

  // -----------------------------------------------------------------
  // Read data selection
  // -----------------------------------------------------------------
  wire  [PAGE_W-1:0] expand_val;
  assign expand_val = (PAGE_W'(1) << BIT_LOC_ABLE)  // R16
                    | (PAGE_W'(1) << BIT_STOR_LOC)  // R16
                    | (PAGE_W'(1) << BIT_NP_ABLE)
                    | (PAGE_W'(page_rx_ff) << BIT_PAGE_RX);

  wire  [PAGE_W-1:0] rd_page    = hit_expand ? expand_val
                                : hit_xmit   ? xmit_ff
                                : hit_recv   ? recv_page
                                : '0;
  wire  [DATA_W-1:0] rd_word    = {{(DATA_W-PAGE_W){1'b0}}, rd_page};

  // -----------------------------------------------------------------
  // Bus handshake
  // -----------------------------------------------------------------
  // One wait state, then a single low cycle closing the access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_ff <= 1'b1;
    end
    else
    begin
      wait_ff <= ~((read | write) & wait_ff);
    end
  end

  // Read data are registered while waitrequest is still high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= '0;
    end
    else if (rd_load)
    begin
      rdata_ff <= rd_word;
    end
  end

  // -----------------------------------------------------------------
  // Transmit page register
  // -----------------------------------------------------------------
  // Software owns bits 15, 13, 12 and the code; hardware owns 14 and 11
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xmit_ff <= PAGE_RST;                                 // R2 R3 R4 R5 R6 R8
    end
    else
    begin
      if (xmit_wr)
      begin
        xmit_ff[BIT_MORE]         <= wr_page[BIT_MORE];    // R2
        xmit_ff[BIT_MSG]          <= wr_page[BIT_MSG];     // R4
        xmit_ff[BIT_COMPLY]       <= wr_page[BIT_COMPLY];  // R5
        xmit_ff[CODE_HI:CODE_LO]  <= wr_page[CODE_HI:CODE_LO]; // R7
      end
      xmit_ff[BIT_ACK] <= local_ack;                       // R3
      if (tx_page_sent)
      begin
        xmit_ff[BIT_TOGGLE] <= ~xmit_ff[BIT_TOGGLE];       // R6
      end
    end
  end

  // -----------------------------------------------------------------
  // Receive page register
  // -----------------------------------------------------------------
  // Partner pages land here whole; bus writes are ignored
  annp_page_hold u_hold
  (
    .clk         (clk),
    .rst         (rst),
    .cap_valid   (rx_page_valid),   // R9 R16
    .cap_word    (rx_page_word),
    .page_ff     (recv_page),
    .captured_ff (recv_done)
  );

  // -----------------------------------------------------------------
  // Page received flag
  // -----------------------------------------------------------------
  // Raised after the page is held; a new page beats a same-cycle read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_rx_ff <= 1'b0;
    end
    else if (recv_done)
    begin
      page_rx_ff <= 1'b1;                                  // R15 R17
    end
    else if (cor_fire)
    begin
      page_rx_ff <= 1'b0;                                  // R15
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign readdata     = rdata_ff;
  assign waitrequest  = wait_ff;
  assign tx_page      = xmit_ff;                           // R1
  assign page_rx_flag = page_rx_ff;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  // A pending request is answered on the next edge
  a_wait_release: assert property (
    @(posedge clk) disable iff (rst)
    ((read | write) && wait_ff) |=> !wait_ff)
    else $error("Request not answered after one wait state");

  // Waitrequest is low for exactly one cycle per access
  a_wait_single: assert property (
    @(posedge clk) disable iff (rst)
    !wait_ff |=> wait_ff)
    else $error("Waitrequest stayed low");

  // Writable transmit bits follow a full-lane write
  a_xmit_write: assert property ( // R2 R4 R5 R7
    @(posedge clk) disable iff (rst)
    (xmit_wr && byteenable[1:0] == 2'b11) |=>
      ((xmit_ff & XMIT_WR_MASK) == ($past(writedata[PAGE_W-1:0]) & XMIT_WR_MASK)))
    else $error("Transmit page write lost");

  // Acknowledge bit tracks the arbitration acknowledge a cycle later
  a_ack_follow: assert property ( // R3
    @(posedge clk) disable iff (rst)
    1'b1 |=> (xmit_ff[BIT_ACK] == $past(local_ack)))
    else $error("Acknowledge bit does not follow arbitration");

  // Toggle inverts after every page sent
  a_toggle_flip: assert property ( // R6
    @(posedge clk) disable iff (rst)
    tx_page_sent |=> (xmit_ff[BIT_TOGGLE] != $past(xmit_ff[BIT_TOGGLE])))
    else $error("Toggle did not invert after send");

  // Toggle holds without a send, whatever software writes
  a_toggle_hold: assert property ( // R6
    @(posedge clk) disable iff (rst)
    !tx_page_sent |=> $stable(xmit_ff[BIT_TOGGLE]))
    else $error("Toggle moved without a send");

  // Received page is held whole on the edge after arrival
  a_recv_capture: assert property ( // R9 R10 R11 R12 R13 R14 R17
    @(posedge clk) disable iff (rst)
    rx_page_valid |=> (recv_page == $past(rx_page_word)))
    else $error("Received page not captured whole");

  // Bus writes never change the received page
  a_recv_readonly: assert property ( // R9
    @(posedge clk) disable iff (rst)
    (!rx_page_valid) |=> $stable(recv_page))
    else $error("Receive page changed without arrival");

  // Flag rises two edges after arrival, never before the page
  a_flag_after: assert property ( // R15 R17
    @(posedge clk) disable iff (rst)
    rx_page_valid |-> ##2 page_rx_ff)
    else $error("Page received flag missing after arrival");

  // Reading the expansion register clears the flag unless a page lands
  a_flag_cor: assert property ( // R15
    @(posedge clk) disable iff (rst)
    (cor_fire && !recv_done) |=> !page_rx_ff)
    else $error("Page received flag not cleared on read");

  // Unmapped reads answer zero
  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (rst)
    (rd_load && !hit_any) |=> (readdata == '0))
    else $error("Unmapped read returned data");

  // A capture pulse beats a same-cycle clearing read
  a_flag_set_wins: assert property ( // R15
    @(posedge clk) disable iff (rst)
    (recv_done && cor_fire) |=> page_rx_ff)
    else $error("Page received flag lost to a same-cycle read");

  // Flag moves only on a capture or a clearing read
  a_flag_hold: assert property ( // R15
    @(posedge clk) disable iff (rst)
    (!recv_done && !cor_fire) |=> $stable(page_rx_ff))
    else $error("Page received flag moved on its own");

  // Flag never rises before the whole page is held
  a_flag_no_early: assert property ( // R17
    @(posedge clk) disable iff (rst)
    (!recv_done && !page_rx_ff) |=> !page_rx_ff)
    else $error("Page received flag rose without a held page");

  // Expansion read shows the fixed capability bits
  a_expand_fixed: assert property ( // R16
    @(posedge clk) disable iff (rst)
    (rd_load && hit_expand) |=>
      (readdata[BIT_LOC_ABLE] && readdata[BIT_STOR_LOC] && readdata[BIT_NP_ABLE]))
    else $error("Expansion capability bits wrong");

  // Expansion read returns the flag as it stood
  a_expand_flag: assert property ( // R15
    @(posedge clk) disable iff (rst)
    (rd_load && hit_expand) |=> (readdata[BIT_PAGE_RX] == $past(page_rx_ff)))
    else $error("Expansion read lost the page received flag");

  // Transmit read returns the register as it stood
  a_xmit_readback: assert property ( // R1
    @(posedge clk) disable iff (rst)
    (rd_load && hit_xmit) |=> (readdata[PAGE_W-1:0] == $past(xmit_ff)))
    else $error("Transmit page read back wrong");

  // Receive read returns the held partner page
  a_recv_readback: assert property ( // R9 R16
    @(posedge clk) disable iff (rst)
    (rd_load && hit_recv) |=> (readdata[PAGE_W-1:0] == $past(recv_page)))
    else $error("Receive page read back wrong");

  // Read data stand until the next read load
  a_rdata_hold: assert property (
    @(posedge clk) disable iff (rst)
    !rd_load |=> $stable(readdata))
    else $error("Read data changed without a read");

  // Writable transmit bits hold without a completed write
  a_xmit_keep: assert property ( // R2 R4 R5 R7
    @(posedge clk) disable iff (rst)
    !xmit_wr |=> ((xmit_ff & XMIT_WR_MASK) == ($past(xmit_ff) & XMIT_WR_MASK)))
    else $error("Transmit page changed without a write");

  // A write without the high lane keeps the upper writable bits
  a_lane_high_keep: assert property ( // R2 R4 R5 R7
    @(posedge clk) disable iff (rst)
    (xmit_wr && !byteenable[1]) |=>
      ((xmit_ff[PAGE_W-1:8] & XMIT_WR_MASK[PAGE_W-1:8])
        == ($past(xmit_ff[PAGE_W-1:8]) & XMIT_WR_MASK[PAGE_W-1:8])))
    else $error("Upper byte changed without its lane");

  // A write without the low lane keeps the low code bits
  a_lane_low_keep: assert property ( // R7
    @(posedge clk) disable iff (rst)
    (xmit_wr && !byteenable[0]) |=> (xmit_ff[7:0] == $past(xmit_ff[7:0])))
    else $error("Low byte changed without its lane");

endmodule : annp_regs

// file: hdl/annp_pkg.sv
// Purpose: Shared constants for the next page register bank
// Assumes: 32-bit register bus, registers one aligned word per index
// Notes:   Byte address of a register is four times its index
package annp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PAGE_W      = 16;
  localparam logic [3:0]  IDX_EXPAND  = 4'h6;  // negotiation_expansion
  localparam logic [3:0]  IDX_XMIT    = 4'h7;  // next_page_transmit
  localparam logic [3:0]  IDX_RECV    = 4'h8;  // next_page_receive

  // ---------------------------------------------------------------
  // Page field layout
  // ---------------------------------------------------------------
  localparam int unsigned BIT_MORE    = 15;    // more_pages_request
  localparam int unsigned BIT_ACK     = 14;    // Acknowledge
  localparam int unsigned BIT_MSG     = 13;    // message_page_flag
  localparam int unsigned BIT_COMPLY  = 12;    // comply_flag
  localparam int unsigned BIT_TOGGLE  = 11;    // page_toggle
  localparam int unsigned CODE_HI     = 10;
  localparam int unsigned CODE_LO     = 0;

  // Software writable bits of the transmit page
  localparam logic [15:0] XMIT_WR_MASK = 16'hB7FF;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PAGE_RST    = 16'h2001;  // Null message page

  // ---------------------------------------------------------------
  // Expansion register bits
  // ---------------------------------------------------------------
  localparam int unsigned BIT_LOC_ABLE = 6;
  localparam int unsigned BIT_STOR_LOC = 5;
  localparam int unsigned BIT_NP_ABLE  = 2;
  localparam int unsigned BIT_PAGE_RX  = 1;

endpackage : annp_pkg

// file: hdl/annp_page_hold.sv
// Purpose: Holds the latest page received from the link partner
// Assumes: cap_valid is a one-cycle pulse with the whole page on cap_word
// Notes:   All sixteen bits load in one edge, and the same edge raises the captured pulse
`timescale 1ns/10ps
module annp_page_hold
  import annp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Capture side
  input  wire logic              cap_valid,
  input  wire logic [PAGE_W-1:0] cap_word,
  // Held page
  output logic [PAGE_W-1:0]      page_ff,
  output logic                   captured_ff
);

  // -----------------------------------------------------------------
  // Page storage
  // -----------------------------------------------------------------
  // Whole page loads at once so software never sees a mixed page
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_ff <= PAGE_RST;                      // R10 R12
    end
    else if (cap_valid)
    begin
      page_ff <= cap_word;                      // R9 R11 R13 R14 R17
    end
  end

  // Marks the edge after which the new page is readable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      captured_ff <= 1'b0;
    end
    else
    begin
      captured_ff <= cap_valid;
    end
  end

endmodule : annp_page_hold

// file: dv/annp_partner.sv
// Purpose: Arbitration side model feeding pages and events to the bank
// Assumes: Pulses last one cycle, driven right after a rising edge
// Notes:   The page word does not hold its value outside a capture pulse
`timescale 1ns/10ps
module annp_partner
  import annp_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Events toward the bank
  output logic              rx_page_valid,
  output logic [PAGE_W-1:0] rx_page_word,
  output logic              local_ack,
  output logic              tx_page_sent
);
  // Idle levels at time zero
  initial
  begin
    rx_page_valid = 1'b0;
    rx_page_word  = 16'h0000;
    local_ack     = 1'b0;
    tx_page_sent  = 1'b0;
  end

  // Whole partner page in one pulse, then the word is scrambled
  task automatic send_page(input logic [PAGE_W-1:0] w);
    @(posedge clk);
    rx_page_valid <= 1'b1;
    rx_page_word  <= w;
    @(posedge clk);
    rx_page_valid <= 1'b0;
    rx_page_word  <= ~w;
  endtask : send_page

  // One transmitted page ends
  task automatic send_toggle();
    @(posedge clk);
    tx_page_sent <= 1'b1;
    @(posedge clk);
    tx_page_sent <= 1'b0;
  endtask : send_toggle

  // Local acknowledge level
  task automatic set_ack(input logic a);
    @(posedge clk);
    local_ack <= a;
  endtask : set_ack
endmodule : annp_partner

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the next page register bank
// Assumes: One wait state per bus access, registers at four times the index
// Notes:   Random stimulus from a fixed seed mixed with fixed corner cases
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import annp_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [3:0]        byteenable = 4'h0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              rx_page_valid, local_ack, tx_page_sent, page_rx_flag;
  logic [PAGE_W-1:0] rx_page_word, tx_page, exp_w = 16'h2001, w;
  logic              ack = 1'b0, tog = 1'b0;
  logic [31:0]       q, r;
  int                n_mismatch = 0;
  int                num_checks = 0;

  annp_regs dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word), .local_ack(local_ack),
    .tx_page_sent(tx_page_sent), .tx_page(tx_page), .page_rx_flag(page_rx_flag));
  annp_partner p_u (.clk(clk), .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word),
    .local_ack(local_ack), .tx_page_sent(tx_page_sent));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    address    <= {idx, 2'b00};
    write      <= wr;
    read       <= !wr;
    writedata  <= {16'hA5A5, d};
    byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
    begin
      n_mismatch++;
      report_and_stop();
    end
    rd    = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  // Expected transmit page from written bits, acknowledge and toggle
  function automatic logic [15:0] xp();
    logic [15:0] t;
    t = exp_w & XMIT_WR_MASK;
    t[BIT_ACK] = ack;
    t[BIT_TOGGLE] = tog;
    return t;
  endfunction : xp

  // Global guard against a hang
  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    void'($urandom(89809));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(tx_page, 16'h2001)
    `CHK(page_rx_flag, 1'b0)
    bus(1'b0, IDX_RECV, 16'h0000, 4'h0, q);
    `CHK(q, 32'h0000_2001)
    bus(1'b0, IDX_EXPAND, 16'h0000, 4'h0, q);
    `CHK(q, 32'h0000_0064)
    bus(1'b1, IDX_RECV, 16'hFFFF, 4'hF, q);
    bus(1'b1, IDX_EXPAND, 16'hFFFF, 4'hF, q);
    bus(1'b0, IDX_RECV, 16'h0000, 4'h0, q);
    `CHK(q, 32'h0000_2001)
    bus(1'b0, 4'hF, 16'h0000, 4'h0, q);
    `CHK(q, 32'h0000_0000)
    // Capture lands on the edge that completes a clearing read
    fork
      bus(1'b0, IDX_EXPAND, 16'h0000, 4'h0, q);
      p_u.send_page(16'h5A5A);
    join
    `CHK(q, 32'h0000_0064)
    #1;
    `CHK(page_rx_flag, 1'b1)
    bus(1'b0, IDX_RECV, 16'h0000, 4'h0, q);
    `CHK(q, 32'h0000_5A5A)
    for (int i = 0; i < 40; i++)
    begin
      r = $urandom;
      w = (i < 4) ? {16{i[0]}} : r[31:16];
      case ((i < 4) ? 2'd0 : r[1:0])
        2'd0:
        begin
          bus(1'b1, IDX_XMIT, w, (i < 4) ? {2'b00, i[1] ^ i[0], !i[0] | i[1]} : r[5:2], q);
          if (q !== 32'hx)
          begin
            exp_w[7:0]  = byteenable[0] ? w[7:0] : exp_w[7:0];
            exp_w[15:8] = byteenable[1] ? w[15:8] : exp_w[15:8];
          end
        end
        2'd1:
        begin
          p_u.send_toggle();
          tog = ~tog;
        end
        2'd2:
        begin
          ack = r[4];
          p_u.set_ack(ack);
          @(posedge clk);
        end
        default:
        begin
          p_u.send_page(w);
          @(posedge clk);
          #1;
          `CHK(page_rx_flag, 1'b1)
          bus(1'b0, IDX_RECV, 16'h0000, 4'h0, q);
          `CHK(q, {16'h0000, w})
          bus(1'b0, IDX_EXPAND, 16'h0000, 4'h0, q);
          `CHK(q, 32'h0000_0066)
          #1;
          `CHK(page_rx_flag, 1'b0)
          bus(1'b1, IDX_XMIT, ~w, 4'h3, q);
          exp_w = ~w;
        end
      endcase
      #1;
      `CHK(tx_page, xp())
      bus(1'b0, IDX_XMIT, 16'h0000, 4'h0, q);
      `CHK(q, {16'h0000, xp()})
    end
    report_and_stop();
  end
endmodule : tb_top
